/* File: rst_seq_pkg.sv */
/*
 * Package for the reset sequencer: phase states, delay counts, vector address.
 * Assumes a single CPU clock domain at 20 MHz.
 */
package rst_seq_pkg;
    localparam int unsigned DELAY_SHORT_CYC = 256;
    localparam int unsigned DELAY_LONG_CYC  = 4096;
    localparam int unsigned FETCH_CYC       = 2;
    localparam int unsigned ACTIVE_CYC      = 4;
    localparam logic [15:0] VEC_ADDR_HI     = 16'hfffe;
    localparam logic [15:0] VEC_ADDR_LO     = 16'hffff;
    localparam int unsigned CNT_W           = 13;
    localparam logic [2:0]  SYNC_RST_VAL    = 3'h7;
    typedef enum logic [1:0] {PH_IDLE, PH_ACTIVE, PH_DELAY, PH_FETCH} phase_e;
endpackage

/* File: pin_sync.sv */
/*
 * Three-flop synchroniser for the reset pin level, with a latched asynchronous
 * request so that a pin pulse is caught even while the clock is stopped.
 * Assumes pin_low_i is the raw pin level inverted (1 = pin low).
 */
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk,       // CPU clock
    input  wire logic rst_n,     // Synchronous reset, active low
    input  wire logic ce,        // Clock enable
    input  wire logic pin_low_i, // Pin seen low, asynchronous
    output logic      req_o      // Synchronised external request
);
    logic       async_req_ff;
    logic [2:0] sync_ff;
    logic       req_ff;

    // Latch set with no clock so a pulse in halt mode is not missed; cleared by the clock.
    always_ff @(posedge clk or posedge pin_low_i) begin
        if (pin_low_i) begin
            async_req_ff <= 1'b1;
        end else if (ce && sync_ff[2] && sync_ff[1]) begin
            async_req_ff <= 1'b0;
        end
    end

    // The first stage feeds only the second; the decision uses stages two and three.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_ff <= rst_seq_pkg::SYNC_RST_VAL;
        end else if (ce) begin
            sync_ff <= {sync_ff[1], sync_ff[0], async_req_ff};
        end
    end

    // A change of level counts only once stages two and three agree, so one late stage
    // that lands on a metastable value cannot start or end a request by itself.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_ff <= 1'b1;
        end else if (ce && (sync_ff[2] == sync_ff[1])) begin
            req_ff <= sync_ff[2];
        end
    end

    assign req_o = req_ff;
endmodule // pin_sync

/* File: reset_sequencer.sv */
/*
 * Reset sequencer: merges reset causes, drives the open-drain reset pin and
 * runs active, delay and vector fetch phases on the CPU clock.
 * Assumes the watchdog, voltage monitor and CPU give same-clock pulses.
 */
// Function
// - Pin, low voltage and watchdog causes all feed one sequencer.
// - Illegal opcode or prebyte also starts a reset sequence.
// - All causes drive the pin; pin held low throughout the delay.
// - Reset vector fetched from addresses fffe and ffff.
// - Phases run active, then delay, then vector fetch.
// - Delay is 256 or 4096 cycles, chosen by option bit.
// - Vector fetch lasts exactly two cycles.
// - Pin is input plus open-drain output with weak pull-up.
// - Pin reset detected without a running clock.
`timescale 1ns/1ps
module reset_sequencer #(
    parameter int unsigned DELAY_LONG = rst_seq_pkg::DELAY_LONG_CYC // Long delay, cycles
) (
    input  wire logic        clk,                // CPU clock, 20 MHz
    input  wire logic        rst_n,              // Synchronous reset, active low
    input  wire logic        ce,                 // Clock enable
    input  wire logic        rst_pin_i,          // Reset pin level in
    output logic             rst_pin_o,          // Reset pin drive value, always 0
    output logic             rst_pin_oe,         // Reset pin output enable
    input  wire logic        low_voltage_detect, // Low-voltage event pulse
    input  wire logic        wdg_reset,          // Watchdog expiry pulse
    input  wire logic        illegal_op,         // Illegal opcode or prebyte pulse
    input  wire logic        long_delay_opt,     // Option bit: 1 selects long delay
    output logic             cpu_reset,          // CPU held in reset
    output logic             vec_fetch,          // Vector fetch phase active
    output logic [15:0]      vec_addr,           // Vector byte address
    output logic             run                 // Normal execution may start
);
    localparam logic [rst_seq_pkg::CNT_W-1:0] CNT_ONE    = {{(rst_seq_pkg::CNT_W-1){1'b0}}, 1'b1};
    localparam logic [rst_seq_pkg::CNT_W-1:0] ACTIVE_LEN =
        rst_seq_pkg::ACTIVE_CYC[rst_seq_pkg::CNT_W-1:0];
    localparam logic [rst_seq_pkg::CNT_W-1:0] FETCH_LEN  =
        rst_seq_pkg::FETCH_CYC[rst_seq_pkg::CNT_W-1:0];

    rst_seq_pkg::phase_e             phase_ff;
    rst_seq_pkg::phase_e             nxt_phase;
    logic [rst_seq_pkg::CNT_W-1:0]   cnt_ff;
    logic [rst_seq_pkg::CNT_W-1:0]   nxt_cnt;
    logic                            ext_req;
    logic                            int_req;
    logic                            any_req;
    logic                            last_cnt;
    logic                            fetch_start;
    logic                            run_ff;
    logic                            nxt_run;
    logic [15:0]                     vec_addr_ff;
    logic [15:0]                     nxt_vec_addr;

    // The pin request arrives through the synchroniser, so it trails the pin by a few
    // cycles; that latency is the price of never sampling the raw pin in the sequencer.
    pin_sync u_pin_sync (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pin_low_i (~rst_pin_i),
        .req_o     (ext_req)
    );

    // Internal causes are same-clock pulses and need no synchroniser.
    assign int_req = low_voltage_detect | wdg_reset | illegal_op;

    // Any cause, from inside or from the pin, restarts the whole sequence.
    assign any_req = int_req | ext_req;

    // True in the last cycle of a counted phase.
    assign last_cnt = (cnt_ff == CNT_ONE);

    function automatic logic [rst_seq_pkg::CNT_W-1:0] delay_len(input logic long_sel);
        delay_len = long_sel ? DELAY_LONG[rst_seq_pkg::CNT_W-1:0]
                             : rst_seq_pkg::DELAY_SHORT_CYC[rst_seq_pkg::CNT_W-1:0];
    endfunction

    // Phases in which the device itself pulls the pin low.
    function automatic logic drives_pin(input rst_seq_pkg::phase_e ph);
        drives_pin = (ph == rst_seq_pkg::PH_ACTIVE) || (ph == rst_seq_pkg::PH_DELAY);
    endfunction

    // The sequence is over and the processor may leave reset.
    function automatic logic is_idle(input rst_seq_pkg::phase_e ph);
        is_idle = (ph == rst_seq_pkg::PH_IDLE);
    endfunction

    // Internal causes give a fixed four-cycle active phase; a pin cause holds it while the synchronised request stays high, then four more cycles.
    // A request wins over every phase transition, so a cause that lands in the last
    // delay cycle still restarts the sequence instead of letting the fetch begin.
    always_comb begin
        nxt_phase = phase_ff;
        nxt_cnt   = cnt_ff;
        if (any_req) begin
            nxt_phase = rst_seq_pkg::PH_ACTIVE;
            nxt_cnt   = ACTIVE_LEN;
        end else begin
            unique case (phase_ff)
                rst_seq_pkg::PH_IDLE: begin
                    nxt_cnt = '0;
                end
                rst_seq_pkg::PH_ACTIVE: begin
                    // The lower bound also catches a count of zero, so the phase cannot hang.
                    if (cnt_ff <= CNT_ONE) begin
                        nxt_phase = rst_seq_pkg::PH_DELAY;
                        nxt_cnt   = delay_len(long_delay_opt);
                    end else begin
                        nxt_cnt = cnt_ff - CNT_ONE;
                    end
                end
                rst_seq_pkg::PH_DELAY: begin
                    if (last_cnt) begin
                        nxt_phase = rst_seq_pkg::PH_FETCH;
                        nxt_cnt   = FETCH_LEN;
                    end else begin
                        nxt_cnt = cnt_ff - CNT_ONE;
                    end
                end
                rst_seq_pkg::PH_FETCH: begin
                    if (last_cnt) begin
                        nxt_phase = rst_seq_pkg::PH_IDLE;
                        nxt_cnt   = '0;
                    end else begin
                        nxt_cnt = cnt_ff - CNT_ONE;
                    end
                end
            endcase
        end
    end

    // Reset leaves the sequencer in the active phase, so the pin is low from the start.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_ff <= rst_seq_pkg::PH_ACTIVE;
        end else if (ce) begin
            phase_ff <= nxt_phase;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= ACTIVE_LEN;
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    // The fetch begins when the delay runs out with no fresh cause pending.
    assign fetch_start = (phase_ff == rst_seq_pkg::PH_DELAY) && last_cnt && !any_req;

    // First fetch cycle reads the high byte address, the second the low one.
    always_comb begin
        nxt_vec_addr = vec_addr_ff;
        if (fetch_start) begin
            nxt_vec_addr = rst_seq_pkg::VEC_ADDR_HI;
        end else if (phase_ff == rst_seq_pkg::PH_FETCH) begin
            nxt_vec_addr = rst_seq_pkg::VEC_ADDR_LO;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vec_addr_ff <= rst_seq_pkg::VEC_ADDR_HI;
        end else if (ce) begin
            vec_addr_ff <= nxt_vec_addr;
        end
    end

    // Run comes from a flop one cycle after idle, so it never glitches on a late cause.
    assign nxt_run = is_idle(phase_ff) && !any_req;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
        end else if (ce) begin
            run_ff <= nxt_run;
        end
    end

    // The pin is driven low in active and delay phases, so every cause is visible outside.
    assign rst_pin_oe = drives_pin(phase_ff);
    // Open drain: the drive value is always low, and the pull-up makes the high level.
    assign rst_pin_o  = 1'b0;
    assign cpu_reset  = !is_idle(phase_ff);
    assign vec_fetch  = (phase_ff == rst_seq_pkg::PH_FETCH);
    assign vec_addr   = vec_addr_ff;
    assign run        = run_ff;
endmodule // reset_sequencer

/* File: rst_seq_properties.sv */
/* Checker on the reset_sequencer ports. Assumes one clock domain; bound below. */
`timescale 1ns/1ps
module rst_seq_properties #(parameter int unsigned DELAY_LONG = 4096) (
    input wire logic        clk, rst_n, ce, rst_pin_i, rst_pin_o, rst_pin_oe, // Pin, clock
    input wire logic        low_voltage_detect, wdg_reset, illegal_op,     // Causes
    input wire logic        long_delay_opt, cpu_reset, vec_fetch, run,     // Sequence
    input wire logic [15:0] vec_addr                                       // Vector address
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire        cause = ce && (low_voltage_detect || wdg_reset || illegal_op);
    logic [12:0] oe_cnt_ff;
    logic        intl_ff;
    // Pin sequences have an open-ended active phase, so only internal causes are timed.
    always_ff @(posedge clk) begin
        if (!rst_n || !rst_pin_i) begin
            oe_cnt_ff <= 13'h0;
            intl_ff   <= 1'b0;
        end else if (cause) begin
            oe_cnt_ff <= 13'h0;
            intl_ff   <= 1'b1;
        end else if (ce && rst_pin_oe) begin
            oe_cnt_ff <= oe_cnt_ff + 13'h1;
        end
    end
    cause_drive_a: assert property (cause |=> rst_pin_oe && cpu_reset && !run)
        else $error("cause did not drive the pin low");
    delay_len_a: assert property ($rose(vec_fetch) && intl_ff |-> oe_cnt_ff ==
        rst_seq_pkg::ACTIVE_CYC + (long_delay_opt ? DELAY_LONG : rst_seq_pkg::DELAY_SHORT_CYC))
        else $error("delay phase has the wrong length");
    fetch_pair_a: assert property ($rose(vec_fetch) |-> vec_addr == 16'hfffe
        ##1 vec_fetch && vec_addr == 16'hffff ##1 !vec_fetch) else $error("bad vector fetch");
    held_low_a: assert property ($rose(vec_fetch) |-> $past(rst_pin_oe))
        else $error("pin released before the fetch");
    run_after_a: assert property ($fell(cpu_reset) |-> $past(vec_fetch) ##1 run)
        else $error("run did not follow the fetch");
    open_drain_a: assert property (rst_pin_oe |-> !rst_pin_o)
        else $error("pin driven high");
    restart_seq_a: assert property (cause && cpu_reset |=> !vec_fetch [*4])
        else $error("sequence not restarted");
    pin_req_a: assert property (ce && !rst_pin_i |-> ##[1:5] rst_pin_oe)
        else $error("pin request not seen");
    run_quiet_a: assert property (run |-> !cpu_reset && !rst_pin_oe)
        else $error("run while in reset");
    cover property ($rose(vec_fetch) && long_delay_opt);
    cover property ($rose(vec_fetch) && !long_delay_opt);
    cover property (cause && cpu_reset);
endmodule // rst_seq_properties
bind reset_sequencer rst_seq_properties #(.DELAY_LONG(DELAY_LONG)) i_props (.clk(clk),
    .rst_n(rst_n), .ce(ce), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .low_voltage_detect(low_voltage_detect), .wdg_reset(wdg_reset), .illegal_op(illegal_op),
    .long_delay_opt(long_delay_opt), .cpu_reset(cpu_reset), .vec_fetch(vec_fetch),
    .run(run), .vec_addr(vec_addr));

/* File: ext_reset_ctl.sv */
/* Outside reset circuit on the reset pin. Assumes the bench asks for each pull. */
`timescale 1ns/1ps
module ext_reset_ctl (
    input  wire logic clk,      // CPU clock
    input  wire logic pull_req, // Request for a low pulse
    output logic      pin_ext   // Outside pin level
);
    logic [2:0] hold_ff = 3'h7; // Starts low: a blank part is held in reset for the first seven cycles.
    always_ff @(posedge clk) begin
        if (pull_req) hold_ff <= 3'h7;
        else if (hold_ff != 3'h0) hold_ff <= hold_ff - 3'h1;
    end
    assign pin_ext = (hold_ff == 3'h0); // Released pin rises on the pull-up.
endmodule // ext_reset_ctl

/* File: reset_sequence_manager_bench.sv */
/* Self-checking bench for reset_sequencer. Assumes ext_reset_ctl on the pin. */
`timescale 1ns/1ps
module reset_sequence_manager_bench;
    localparam int unsigned DL = 16; // Shortened long delay keeps the run brief.
    logic clk = 1'b0, rst_n = 1'b0, pull_req = 1'b0, long_opt = 1'b0, pin_ext, ce = 1'b1;
    logic [2:0] cause = 3'h0;
    logic pin_o, pin_oe, cpu_reset, vec_fetch, run;
    logic [15:0] vec_addr;
    int miscompares = 0, num_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    reset_sequencer #(.DELAY_LONG(DL)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .rst_pin_i(pin_ext), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
        .low_voltage_detect(cause[0]), .wdg_reset(cause[1]), .illegal_op(cause[2]),
        .long_delay_opt(long_opt), .cpu_reset(cpu_reset), .vec_fetch(vec_fetch),
        .vec_addr(vec_addr), .run(run));
    ext_reset_ctl i_ext (.clk(clk), .pull_req(pull_req), .pin_ext(pin_ext));
    task give_verdict();
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task pulse(input logic [2:0] c, input logic lo);
        @(posedge clk);
        cause <= c;
        long_opt <= lo; // Delay option taken from the caller's lo argument.
        @(posedge clk);
        cause <= 3'h0;
        #1;
        check("pin_oe", 16'h1, {15'h0, pin_oe});
    endtask
    task finish_seq(input int unsigned exp_cnt);
        int n;
        n = 0;
        while (vec_fetch !== 1'b1) begin
            if (pin_oe === 1'b1) n++;
            @(posedge clk);
            #1;
        end
        if (exp_cnt != 0) check("low_cycles", 16'(exp_cnt), 16'(n));
        check("addr_hi", 16'hfffe, vec_addr);
        @(posedge clk);
        #1;
        check("addr_lo", 16'hffff, vec_addr);
        @(posedge clk);
        #1;
        check("fetch_end", 16'h0, {14'h0, vec_fetch, cpu_reset});
        @(posedge clk);
        #1;
        check("run", 16'h1, {15'h0, run});
    endtask
    task t_causes();
        for (int i = 0; i < 6; i++) begin
            pulse(3'(1 << (i / 2)), i[0]);
            finish_seq(4 + (i[0] ? DL : 256));
        end
    endtask
    task t_restart();
        pulse(3'h2, 1'b0);
        repeat (20) @(posedge clk);
        pulse(3'h1, 1'b0);
        finish_seq(260);
    endtask
    task t_pin();
        @(posedge clk);
        pull_req <= 1'b1;
        @(posedge clk);
        pull_req <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check("pin_seen", 16'h1, {15'h0, pin_oe});
        finish_seq(0);
    endtask
    task t_freeze();
        pulse(3'h4, 1'b0);
        @(posedge clk);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        #1;
        // Ten frozen cycles stretch the sequence; counting starts after them.
        finish_seq(259);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        finish_seq(0);
        t_causes();
        t_restart();
        t_pin();
        t_freeze();
        give_verdict();
    end
endmodule // reset_sequence_manager_bench
